/* File: hdl/tsip_pkg.sv */
/*
 * tsip_pkg: constants, states and state records of the temperature
 * sensor two-wire target port.
 * Assumes a 250 MHz core clock and a separate bus sampling clock.
 */
package tsip_pkg;

    localparam int          CLK_MHZ      = 250;
    localparam int          BUSY_TIME_US = 200;
    localparam int          BUSY_CYCLES  = BUSY_TIME_US * CLK_MHZ;
    localparam int          BUSY_W       = 16;

    localparam logic [4:0]  ADDR_HI      = 5'h12;
    localparam logic [7:0]  GCALL_ADDR   = 8'h00;
    localparam logic [7:0]  GCALL_RESET  = 8'h06;
    localparam logic [7:0]  PTR_RESET    = 8'h2f;

    localparam logic [7:0]  PTR_TEMP_MSB = 8'h00;
    localparam logic [7:0]  PTR_TEMP_LSB = 8'h01;
    localparam logic [7:0]  PTR_STATUS   = 8'h02;
    localparam logic [7:0]  PTR_CONFIG   = 8'h03;
    localparam logic [7:0]  PTR_HIGH_MSB = 8'h04;
    localparam logic [7:0]  PTR_HIGH_LSB = 8'h05;
    localparam logic [7:0]  PTR_LOW_MSB  = 8'h06;
    localparam logic [7:0]  PTR_LOW_LSB  = 8'h07;
    localparam logic [7:0]  PTR_CRIT_MSB = 8'h08;
    localparam logic [7:0]  PTR_CRIT_LSB = 8'h09;
    localparam logic [7:0]  PTR_HYST     = 8'h0a;
    localparam logic [7:0]  PTR_ID       = 8'h0b;

    localparam logic [7:0]  CFG_RST      = 8'h00;
    localparam logic [15:0] HIGH_RST     = 16'h2000;
    localparam logic [15:0] LOW_RST      = 16'h0500;
    localparam logic [15:0] CRIT_RST     = 16'h4980;
    localparam logic [3:0]  HYST_RST     = 4'h5;

    typedef enum logic [2:0] {
        TSIP_IDLE  = 3'b000,
        TSIP_ADDR  = 3'b001,
        TSIP_AACK  = 3'b010,
        TSIP_WBYTE = 3'b011,
        TSIP_WACK  = 3'b100,
        TSIP_RBYTE = 3'b101,
        TSIP_RACK  = 3'b110
    } tsip_state_t;

    typedef struct packed {
        logic [15:0] temp;
        logic [7:0]  status;
    } tsip_sample_t;

    typedef struct packed {
        logic        pin_lo;
        logic        oe;
    } tsip_od_pin_t;

    typedef struct packed {
        tsip_state_t  st;
        logic         scl_q, sda_q, rw, gc, mack, oe, pend;
        logic         rst_tgl, req_seen;
        logic [3:0]   cnt;
        logic [1:0]   idx;
        logic [7:0]   sh, tx, ptr, cfg;
        tsip_sample_t smp;
        logic [15:0]  hi, lo, cr;
        logic [3:0]   hy;
    } tsip_link_t;

    typedef struct packed {
        logic              req, rst_seen, busy;
        tsip_sample_t      word;
        logic [BUSY_W-1:0] cnt;
        tsip_od_pin_t      alarm, crit;
    } tsip_core_t;

endpackage

/* File: hdl/tsip_sync.sv */
/*
 * tsip_sync: two flip-flop level synchroniser, one bit per lane.
 * Assumes its inputs are levels that stay put for several clocks.
 */
`timescale 1ns/1ps
module tsip_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] q_out_unused_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_reg <= INIT;
            q_out    <= INIT;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

/* File: hdl/tsip_top.sv */
/*
 * tsip_top: two-wire target port of a temperature sensor with its
 * byte-wide register file, reset command handling and alarm pins.
 * Assumes bus lines and straps come from pins, link_clk_in samples
 * the bus well above the bus clock rate, and the sensor core feeds
 * temperature, status and alarm requests on clk_in.
 */
`timescale 1ns/1ps
// Functional notes
// - address 10010 plus two strap bits
// - shift eight bits, address msb first
// - acknowledge own or general call address, else stay idle
// - direction bit zero writes, one reads
// - nine clocks per byte, data changes low
// - rising data with clock high is stop
// - one direction per transaction
// - first written byte loads the pointer
// - limit writes take upper then lower byte
// - extra written bytes are discarded
// - sixteen-bit registers read two bytes, upper first
// - pointer advances only upper to lower
// - reads use the pointer already held
// - pointer 0x2f reloads defaults, then busy
// - general call with 0x06 reloads defaults
// - no address acknowledges during reload window
// - other general call bytes are not acknowledged
// - alarm pins are open drain
// - limit pairs at 0x04 to 0x09
module tsip_top #(
    parameter int         BUSY_CYC = tsip_pkg::BUSY_CYCLES,
    parameter logic [4:0] MFR_ID   = 5'h0a, // arbitrary, no maker's code
    parameter logic [2:0] REV_ID   = 3'h1
) (
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              link_clk_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    input  wire logic              addr_strap_bit0,
    input  wire logic              addr_strap_bit1,
    input  wire tsip_pkg::tsip_sample_t sample_in,
    input  wire logic              alarm_req_in,
    input  wire logic              crit_req_in,
    output logic                   alarm_out,
    output logic                   alarm_oe_out,
    output logic                   critical_alarm_out,
    output logic                   critical_alarm_oe_out,
    output logic                   busy_out
);
    import tsip_pkg::*;
    localparam tsip_link_t LINK_RST = '{st: TSIP_IDLE, scl_q: 1'b1,
        sda_q: 1'b1, ptr: PTR_TEMP_MSB, cfg: CFG_RST, hi: HIGH_RST,
        lo: LOW_RST, cr: CRIT_RST, hy: HYST_RST, default: '0};
    localparam tsip_core_t CORE_RST = '0;
    tsip_link_t ls_reg, ls_next;
    tsip_core_t cs_reg, cs_next;
    logic       lrst_n;
    logic       scl_s, sda_s, req_s, busy_s, rst_s, ack_s;
    logic [1:0] strap_s;
    // link domain reset and pin sampling
    tsip_sync #(.W(1), .INIT(1'b0)) u_lrst (
        .clk_in          (link_clk_in),
        .nrst_in         (1'b1),
        .d_in            (nrst_in),
        .q_out_unused_in (1'b0),
        .q_out           (lrst_n)
    );
    tsip_sync #(.W(6), .INIT(6'h30)) u_lsync (
        .clk_in          (link_clk_in),
        .nrst_in         (lrst_n),
        .d_in            ({scl_in, sda_in, addr_strap_bit1,
                           addr_strap_bit0, cs_reg.req, cs_reg.busy}),
        .q_out_unused_in (6'h00),
        .q_out           ({scl_s, sda_s, strap_s, req_s, busy_s})
    );
    tsip_sync #(.W(2), .INIT(2'h0)) u_csync (
        .clk_in          (clk_in),
        .nrst_in         (nrst_in),
        .d_in            ({ls_reg.rst_tgl, ls_reg.req_seen}),
        .q_out_unused_in (2'h0),
        .q_out           ({rst_s, ack_s})
    );
    logic start_c, stop_c, rise_c, fall_c, blk_c, at8_c;
    // start and stop seen only with the clock held high
    assign start_c = scl_s & ls_reg.scl_q & ls_reg.sda_q & ~sda_s;
    assign stop_c  = scl_s & ls_reg.scl_q & ~ls_reg.sda_q & sda_s;
    assign rise_c  = scl_s & ~ls_reg.scl_q;
    assign fall_c  = ~scl_s & ls_reg.scl_q;
    assign blk_c   = ls_reg.pend | busy_s;
    assign at8_c   = fall_c && (ls_reg.cnt == 4'h8);
    function automatic logic is_msb(input logic [7:0] p);
        return (p == PTR_TEMP_MSB) || (p == PTR_HIGH_MSB) ||
               (p == PTR_LOW_MSB) || (p == PTR_CRIT_MSB);
    endfunction
    function automatic logic [7:0] rd_byte(input tsip_link_t s);
        case (s.ptr)
            PTR_TEMP_MSB: rd_byte = s.smp.temp[15:8];
            PTR_TEMP_LSB: rd_byte = s.smp.temp[7:0];
            PTR_STATUS:   rd_byte = s.smp.status;
            PTR_CONFIG:   rd_byte = s.cfg;
            PTR_HIGH_MSB: rd_byte = s.hi[15:8];
            PTR_HIGH_LSB: rd_byte = s.hi[7:0];
            PTR_LOW_MSB:  rd_byte = s.lo[15:8];
            PTR_LOW_LSB:  rd_byte = s.lo[7:0];
            PTR_CRIT_MSB: rd_byte = s.cr[15:8];
            PTR_CRIT_LSB: rd_byte = s.cr[7:0];
            PTR_HYST:     rd_byte = {4'h0, s.hy};
            PTR_ID:       rd_byte = {MFR_ID, REV_ID};
            default:      rd_byte = 8'h00;
        endcase
    endfunction
    always_comb begin
        logic       we, fire;
        logic [7:0] wa, rd;
        ls_next   = ls_reg;
        we        = 1'b0;
        fire      = 1'b0;
        wa        = ls_reg.ptr;
        rd        = rd_byte(ls_reg);
        ls_next.scl_q = scl_s;
        ls_next.sda_q = sda_s;
        if (req_s != ls_reg.req_seen) begin
            ls_next.req_seen = req_s;
            ls_next.smp      = cs_reg.word;
        end
        if (busy_s) begin
            ls_next.pend = 1'b0;
        end
        if (start_c) begin
            ls_next.st  = TSIP_ADDR;
            ls_next.cnt = 4'h0;
            ls_next.oe  = 1'b0;
            ls_next.idx = 2'h0;
        end else if (stop_c) begin
            ls_next.st = TSIP_IDLE;
            ls_next.oe = 1'b0;
        end else begin
            case (ls_reg.st)
                TSIP_ADDR: begin
                    if (rise_c) begin
                        ls_next.sh  = {ls_reg.sh[6:0], sda_s};
                        ls_next.cnt = 4'(ls_reg.cnt + 4'h1);
                    end else if (at8_c) begin
                        ls_next.rw = ls_reg.sh[0];
                        ls_next.gc = (ls_reg.sh == GCALL_ADDR);
                        // match own or general call, never while busy
                        if (!blk_c && (ls_reg.sh[7:1] ==
                                {ADDR_HI, strap_s} ||
                                ls_reg.sh == GCALL_ADDR)) begin
                            ls_next.oe = 1'b1;
                            ls_next.st = TSIP_AACK;
                        end else begin
                            ls_next.st = TSIP_IDLE;
                        end
                    end
                end
                TSIP_AACK: begin
                    if (fall_c) begin
                        ls_next.cnt = 4'h0;
                        if (ls_reg.rw) begin
                            ls_next.tx = rd;
                            ls_next.oe = ~rd[7];
                            ls_next.st = TSIP_RBYTE;
                        end else begin
                            ls_next.oe = 1'b0;
                            ls_next.st = TSIP_WBYTE;
                        end
                    end
                end
                TSIP_WBYTE: begin
                    if (rise_c) begin
                        ls_next.sh  = {ls_reg.sh[6:0], sda_s};
                        ls_next.cnt = 4'(ls_reg.cnt + 4'h1);
                    end else if (at8_c) begin
                        ls_next.oe = 1'b1;
                        ls_next.st = TSIP_WACK;
                        if (ls_reg.gc) begin
                            if (ls_reg.sh == GCALL_RESET) begin
                                fire = 1'b1;
                            end else begin
                                ls_next.oe = 1'b0;
                                ls_next.st = TSIP_IDLE;
                            end
                        end else if (ls_reg.idx == 2'h0) begin
                            ls_next.ptr = ls_reg.sh;
                            fire = (ls_reg.sh == PTR_RESET);
                        end else if (ls_reg.idx == 2'h1) begin
                            we = 1'b1;
                        end else if (ls_reg.idx == 2'h2 &&
                                     is_msb(ls_reg.ptr)) begin
                            we = 1'b1;
                            wa = 8'(ls_reg.ptr + 8'h01);
                        end
                        // later bytes are acknowledged and dropped
                        if (ls_reg.idx != 2'h3) begin
                            ls_next.idx = 2'(ls_reg.idx + 2'h1);
                        end
                    end
                end
                TSIP_WACK: begin
                    if (fall_c) begin
                        ls_next.oe  = 1'b0;
                        ls_next.cnt = 4'h0;
                        ls_next.st  = ls_reg.pend ? TSIP_IDLE : TSIP_WBYTE;
                    end
                end
                TSIP_RBYTE: begin
                    if (rise_c) begin
                        ls_next.cnt = 4'(ls_reg.cnt + 4'h1);
                    end else if (at8_c) begin
                        ls_next.oe = 1'b0;
                        ls_next.st = TSIP_RACK;
                        if (is_msb(ls_reg.ptr)) begin
                            ls_next.ptr = 8'(ls_reg.ptr + 8'h01);
                        end
                    end else if (fall_c) begin
                        ls_next.tx = {ls_reg.tx[6:0], 1'b0};
                        ls_next.oe = ~ls_reg.tx[6];
                    end
                end
                TSIP_RACK: begin
                    if (rise_c) begin
                        ls_next.mack = ~sda_s;
                    end else if (fall_c) begin
                        if (ls_reg.mack) begin
                            ls_next.tx  = rd;
                            ls_next.oe  = ~rd[7];
                            ls_next.cnt = 4'h0;
                            ls_next.st  = TSIP_RBYTE;
                        end else begin
                            ls_next.st = TSIP_IDLE;
                        end
                    end
                end
                default: ls_next.st = TSIP_IDLE;
            endcase
        end
        if (we) begin
            case (wa)
                PTR_CONFIG:   ls_next.cfg       = ls_reg.sh;
                PTR_HIGH_MSB: ls_next.hi[15:8]  = ls_reg.sh;
                PTR_HIGH_LSB: ls_next.hi[7:0]   = ls_reg.sh;
                PTR_LOW_MSB:  ls_next.lo[15:8]  = ls_reg.sh;
                PTR_LOW_LSB:  ls_next.lo[7:0]   = ls_reg.sh;
                PTR_CRIT_MSB: ls_next.cr[15:8]  = ls_reg.sh;
                PTR_CRIT_LSB: ls_next.cr[7:0]   = ls_reg.sh;
                PTR_HYST:     ls_next.hy        = ls_reg.sh[3:0];
                default:      ;
            endcase
        end
        if (fire) begin
            // reload defaults and open the busy window
            ls_next.ptr     = PTR_TEMP_MSB;
            ls_next.cfg     = CFG_RST;
            ls_next.hi      = HIGH_RST;
            ls_next.lo      = LOW_RST;
            ls_next.cr      = CRIT_RST;
            ls_next.hy      = HYST_RST;
            ls_next.pend    = 1'b1;
            ls_next.rst_tgl = ~ls_reg.rst_tgl;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (!lrst_n) begin
            ls_reg <= LINK_RST;
        end else begin
            ls_reg <= ls_next;
        end
    end
    always_comb begin
        cs_next = cs_reg;
        cs_next.alarm.oe = alarm_req_in;
        cs_next.crit.oe  = crit_req_in;
        if (cs_reg.req == ack_s) begin
            cs_next.word = sample_in;
            cs_next.req  = ~cs_reg.req;
        end
        if (rst_s != cs_reg.rst_seen) begin
            cs_next.rst_seen = rst_s;
            cs_next.cnt      = BUSY_W'(BUSY_CYC);
        end else if (cs_reg.cnt != '0) begin
            cs_next.cnt = BUSY_W'(cs_reg.cnt - 1'b1);
        end
        cs_next.busy = (cs_next.cnt != '0);
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cs_reg <= CORE_RST;
        end else begin
            cs_reg <= cs_next;
        end
    end
    // bus data line only ever pulled low
    assign sda_out               = 1'b0;
    assign sda_oe_out            = ls_reg.oe;
    assign alarm_out             = cs_reg.alarm.pin_lo;
    assign alarm_oe_out          = cs_reg.alarm.oe;
    assign critical_alarm_out    = cs_reg.crit.pin_lo;
    assign critical_alarm_oe_out = cs_reg.crit.oe;
    assign busy_out              = cs_reg.busy;
    // link domain checks
    chk_addr_ack: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_ADDR && at8_c && !start_c && !stop_c && !blk_c
         && ls_reg.sh[7:1] == {ADDR_HI, strap_s})
        |=> (ls_reg.oe && ls_reg.st == TSIP_AACK))
        else $error("own address not acknowledged");
    chk_busy_nack: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_AACK && $past(ls_reg.st) == TSIP_ADDR)
        |-> $past(!blk_c))
        else $error("acknowledge given while busy");
    chk_gcall_nack: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_WBYTE && ls_reg.gc && at8_c && !start_c &&
         !stop_c && ls_reg.sh != GCALL_RESET)
        |=> (!ls_reg.oe && ls_reg.st == TSIP_IDLE))
        else $error("bad general call acknowledged");
    chk_ptr_load: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_WBYTE && !ls_reg.gc && ls_reg.idx == 2'h0 &&
         at8_c && !start_c && !stop_c && ls_reg.sh != PTR_RESET)
        |=> (ls_reg.ptr == $past(ls_reg.sh)))
        else $error("pointer not loaded");
    chk_auto_inc: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_RBYTE && at8_c && !start_c && !stop_c)
        |=> (ls_reg.ptr == (is_msb($past(ls_reg.ptr)) ?
             8'($past(ls_reg.ptr) + 8'h01) : $past(ls_reg.ptr))))
        else $error("pointer advance wrong");
    chk_oe_scl_low: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        ($changed(ls_reg.oe) && !$past(start_c) && !$past(stop_c))
        |-> !$past(scl_s))
        else $error("data line moved with clock high");
    chk_stop_idle: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        stop_c |=> (ls_reg.st == TSIP_IDLE && !ls_reg.oe))
        else $error("stop not honoured");
    chk_reset_cmd: assert property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        (ls_reg.st == TSIP_WBYTE && !ls_reg.gc && ls_reg.idx == 2'h0 &&
         at8_c && !start_c && !stop_c && ls_reg.sh == PTR_RESET)
        |=> (ls_reg.pend && ls_reg.hi == HIGH_RST && ls_reg.cr == CRIT_RST))
        else $error("reset command not taken");
    // core domain checks
    chk_busy_hold: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        $rose(cs_reg.busy) |-> cs_reg.busy[*8])
        else $error("busy window too short");
    chk_alarm_od: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        crit_req_in |=> (critical_alarm_oe_out && !critical_alarm_out))
        else $error("critical pin not pulled low");
    cov_addr_ack: cover property (@(posedge link_clk_in)
        disable iff (!lrst_n) ls_reg.st == TSIP_AACK);
    cov_two_byte: cover property (@(posedge link_clk_in)
        disable iff (!lrst_n)
        ls_reg.st == TSIP_RBYTE && ls_reg.ptr == PTR_TEMP_LSB);
    cov_gc_reset: cover property (@(posedge link_clk_in)
        disable iff (!lrst_n) ls_reg.gc && $rose(ls_reg.pend));
endmodule

/* File: sim/tsip_master.sv */
/*
 * tsip_master: two-wire bus master model for the target port.
 * Assumes a pulled-up data line and a caller clock of 4 ns.
 */
`timescale 1ns/1ps
module tsip_master (
    input  wire logic clk_in,
    input  wire logic dev_oe_in,
    output logic      scl_out,
    output logic      sda_out
);
    logic low;
    // wired data line, pull-up when nobody pulls
    assign sda_out = !(low || dev_oe_in);
    initial begin
        scl_out = 1'b1;
        low = 1'b0;
    end
    task automatic ph(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // also serves as repeated start
    task automatic start();
        ph(15);
        low = 1'b0;
        ph(50);
        scl_out = 1'b1;
        ph(50);
        low = 1'b1;
        ph(50);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        ph(15);
        low = 1'b1;
        ph(50);
        scl_out = 1'b1;
        ph(50);
        low = 1'b0;
        ph(50);
    endtask
    // data moves only while clock low
    task automatic bit_io(input logic b, output logic s);
        ph(15);
        low = !b;
        ph(50);
        scl_out = 1'b1;
        ph(50);
        s = sda_out;
        scl_out = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] w, input logic nak,
                        output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], s);
            r[i] = s;
        end
        bit_io(nak, s);
        ack = !s;
    endtask
endmodule

/* File: sim/tsip_top_tb.sv */
/*
 * tsip_top_tb: self-checking bench for the two-wire target port.
 * Assumes the master model drives the bus; straps end at 2'b11.
 */
`timescale 1ns/1ps
module tsip_top_tb;
    import tsip_pkg::*;
    localparam logic [7:0] AW = 8'h96;
    localparam logic [7:0] AR = 8'h97;
    logic         clk, lclk, nrst, strap0, strap1, areq, creq;
    logic         scl, sda, sdo, oe, aoe, coe, ao, co, busy;
    tsip_sample_t smp;
    int           fails, num_checks;
    // id values are arbitrary
    tsip_top #(.BUSY_CYC(2000), .MFR_ID(5'h0c), .REV_ID(3'h2)) dut (
        .clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk),
        .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_out(oe),
        .addr_strap_bit0(strap0), .addr_strap_bit1(strap1),
        .sample_in(smp), .alarm_req_in(areq), .crit_req_in(creq),
        .alarm_out(ao), .alarm_oe_out(aoe), .critical_alarm_out(co),
        .critical_alarm_oe_out(coe), .busy_out(busy));
    tsip_master m (.clk_in(clk), .dev_oe_in(oe), .scl_out(scl),
                   .sda_out(sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #5.3;
        forever #16 lclk = ~lclk;
    end
    task automatic chk(input string w, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] b, input logic a, input string w);
        logic [7:0] r;
        logic       k;
        m.xfer(b, 1'b1, r, k);
        chk(w, {7'h0, a}, {7'h0, k});
    endtask
    task automatic rb(input logic n, input logic [7:0] e, input string w);
        logic [7:0] r;
        logic       k;
        m.xfer(8'hff, n, r, k);
        chk(w, e, r);
    endtask
    task automatic rd1(input logic [7:0] p, e, input string w);
        m.start();
        wr(AW, 1'b1, "addr");
        wr(p, 1'b1, "ptr");
        m.start();
        wr(AR, 1'b1, "addr");
        rb(1'b1, e, w);
        m.stop();
    endtask
    // refused address while busy, then bounded wait for the end
    task automatic busy_win();
        chk("busy", 8'h01, {7'h0, busy});
        m.start();
        wr(AW, 1'b0, "busy nak");
        m.stop();
        for (int n = 0; n < 4000 && busy !== 1'b0; n++)
            @(negedge clk);
        chk("busy end", 8'h00, {7'h0, busy});
        if (busy !== 1'b0)
            wrap_up();
    endtask
    task automatic s_addr();
        for (int s = 0; s < 4; s++) begin
            {strap1, strap0} = s[1:0];
            repeat (100) @(negedge clk);
            m.start();
            wr({5'h12, s[1:0], 1'b0}, 1'b1, "own");
            m.stop();
            m.start();
            wr({5'h12, ~s[1:0], 1'b0}, 1'b0, "other");
            m.stop();
        end
    endtask
    task automatic s_alarm();
        for (int i = 1; i < 3; i++) begin
            {areq, creq} = i[1:0];
            repeat (2) @(negedge clk);
            chk("od", {4'h0, i[1:0], 2'b00}, {4'h0, aoe, coe, ao, co});
        end
        chk("sda val", 8'h00, {7'h0, sdo});
    endtask
    task automatic s_limit();
        m.start();
        wr(AW, 1'b1, "addr w");
        wr(PTR_HIGH_MSB, 1'b1, "ptr");
        wr(8'h12, 1'b1, "hi msb");
        wr(8'h34, 1'b1, "hi lsb");
        wr(8'h56, 1'b1, "extra");
        m.start();
        wr(AR, 1'b1, "addr r");
        rb(1'b0, 8'h12, "rd msb");
        rb(1'b1, 8'h34, "rd lsb");
        m.stop();
        rd1(PTR_LOW_MSB, 8'h05, "lo kept");
    endtask
    task automatic s_cfg();
        m.start();
        wr(AW, 1'b1, "addr");
        wr(PTR_CONFIG, 1'b1, "ptr");
        wr(8'ha5, 1'b1, "cfg");
        m.stop();
        m.start();
        wr(AR, 1'b1, "addr");
        rb(1'b0, 8'ha5, "cfg rd");
        rb(1'b1, 8'ha5, "cfg rep");
        m.stop();
        m.start();
        wr(AW, 1'b1, "addr");
        wr(PTR_HYST, 1'b1, "ptr");
        wr(8'hfa, 1'b1, "hy");
        m.stop();
        rd1(PTR_HYST, 8'h0a, "hy rd");
    endtask
    task automatic s_reset();
        m.start();
        wr(AW, 1'b1, "addr");
        wr(PTR_RESET, 1'b1, "rst cmd");
        m.stop();
        busy_win();
        rd1(PTR_HIGH_MSB, 8'h20, "hi dflt");
        rd1(PTR_HYST, 8'h05, "hy dflt");
        m.start();
        wr(8'h00, 1'b1, "gc addr");
        wr(8'h07, 1'b0, "gc other");
        m.stop();
        m.start();
        wr(8'h00, 1'b1, "gc addr");
        wr(GCALL_RESET, 1'b1, "gc rst");
        m.stop();
        busy_win();
        rd1(PTR_CONFIG, 8'h00, "cfg dflt");
    endtask
    task automatic s_temp();
        rd1(PTR_TEMP_MSB, 8'hbe, "temp msb");
        m.start();
        wr(AR, 1'b1, "addr");
        rb(1'b1, 8'hef, "temp lsb");
        m.stop();
        rd1(PTR_STATUS, 8'h5a, "status");
        rd1(PTR_ID, 8'h62, "id");
    endtask
    initial begin
        fails = 0;
        num_checks = 0;
        {nrst, strap1, strap0, areq, creq} = '0;
        smp = {16'hbeef, 8'h5a};
        repeat (40) @(negedge clk);
        nrst = 1'b1;
        s_addr();
        s_alarm();
        s_limit();
        s_cfg();
        s_reset();
        s_temp();
        wrap_up();
    end
endmodule
